// ---- design/exec_adder.sv ----
`timescale 1ns/1ps

// ****************************************
// Add with carry and flag generation
// ****************************************
module exec_adder #(
  parameter int W = 8
) (
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  input wire logic cin,
  output exec_pkg::add_res_t res
);

  logic [4:0] low_nib; // Low nibble sum, bit 4 is half carry
  logic [W-2:0] low7; // Carry into the top bit comes from here
  logic [W-1:0] low7_sum;
  logic [W:0] full; // Full sum with carry out

  // Overflow is carry into top bit xor carry out of top bit
  always_comb begin
    low_nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    low7 = a[W-2:0];
    low7_sum = {1'b0, low7} + {1'b0, b[W-2:0]} + {{(W-1){1'b0}}, cin};
    full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
    res.sum = full[W-1:0];
    res.c = full[W];
    res.ac = low_nib[4];
    res.ov = low7_sum[W-1] ^ full[W];
    res.z = (full[W-1:0] == exec_pkg::ZERO_BYTE);
  end

endmodule : exec_adder

// ---- design/exec_core.sv ----
`timescale 1ns/1ps
// How it works
// - Program counter low write adds one cycle
// - Taken skip adds one instruction cycle
// - Untaken skip keeps nominal cycle count
// - Preclear clears flags only when watchdog cleared
// - Add with carry into working register
// - Add with carry into data memory
// - AND into register, zero flag only
// - Complement every bit, update zero flag
// - Complement result to register, memory untouched
// - Halt stops execution, gates system clock
// - Halt keeps memory and registers intact
// - Halt clears watchdog counter and prescaler
// - Halt sets power-down, clears timeout
// - Bit index selects positions zero to seven

// ****************************************
// Instruction execution core
// ****************************************
module exec_core #(
  parameter int DATA_W = exec_pkg::DATA_W,
  parameter int DEPTH = 256,
  parameter int WDT_W = 16,
  parameter int PRESC_W = 8
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic INSTR_VALID,
  input wire exec_pkg::instr_t INSTR,
  input wire logic [DATA_W-1:0] PC_LOW_DATA,
  input wire logic WAKE,
  output logic INSTR_READY,
  output logic DONE,
  output logic SKIP_NEXT,
  output logic [DATA_W-1:0] ACC,
  output logic [DATA_W-1:0] PROGRAM_COUNTER_LOW_BYTE,
  output exec_pkg::flags_t FLAGS,
  output logic [WDT_W-1:0] WATCHDOG_COUNTER,
  output logic WATCHDOG_EXPIRED,
  output logic SYS_CLK_EN,
  output logic HALTED
);

  typedef enum {ST_IDLE, ST_EXEC, ST_EXTRA, ST_HALT} state_t;

  // ****************************************
  // State declarations
  // ****************************************
  state_t state_r, state_nxt;
  logic [1:0] phase_r, phase_nxt; // System clock within a cycle
  exec_pkg::instr_t cur_r, cur_nxt; // Instruction held while executing
  logic [DATA_W-1:0] mem_r [DEPTH]; // Data memory
  logic mem_we; // Data memory write strobe
  logic [DATA_W-1:0] mem_wd;
  logic [DATA_W-1:0] acc_r, acc_nxt;
  logic [DATA_W-1:0] pcl_r, pcl_nxt;
  exec_pkg::flags_t flags_r, flags_nxt;
  logic [WDT_W-1:0] wdt_r, wdt_nxt; // Watchdog counter
  logic [PRESC_W-1:0] presc_r, presc_nxt; // Watchdog prescaler
  logic pre1_r, pre1_nxt; // First preclear seen
  logic pre2_r, pre2_nxt; // Second preclear seen
  logic done_r, done_nxt;
  logic skip_r, skip_nxt;
  logic [DATA_W-1:0] mem_rd; // Addressed data byte
  exec_pkg::add_res_t add_res;
  // Bit select; a three bit index can only name bits zero to seven
  function automatic logic bit_of(input logic [DATA_W-1:0] v,
                                  input logic [2:0] idx);
    bit_of = v[idx];
  endfunction : bit_of
  assign mem_rd = mem_r[cur_r.addr];
  exec_adder #(.W(DATA_W)) u_add (
    .a(acc_r),
    .b(mem_rd),
    .cin(flags_r.carry_flag),
    .res(add_res)
  );

  // ****************************************
  // Next state of sequencer, datapath, watchdog
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r + 2'h1;
    cur_nxt = cur_r;
    acc_nxt = acc_r;
    pcl_nxt = pcl_r;
    flags_nxt = flags_r;
    mem_we = 1'b0;
    mem_wd = add_res.sum;
    pre1_nxt = pre1_r;
    pre2_nxt = pre2_r;
    done_nxt = 1'b0;
    skip_nxt = skip_r;
    // Watchdog counts through the prescaler and holds once it reaches the top
    presc_nxt = presc_r + {{(PRESC_W-1){1'b0}}, 1'b1};
    wdt_nxt = wdt_r;
    if (&presc_r && !(&wdt_r)) begin
      wdt_nxt = wdt_r + {{(WDT_W-1){1'b0}}, 1'b1};
    end
    unique case (state_r)
      ST_IDLE: begin
        phase_nxt = 2'h0;
        if (INSTR_VALID) begin
          cur_nxt = INSTR;
          skip_nxt = 1'b0;
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        // Work is committed on the last clock of the cycle
        if (phase_r == exec_pkg::PHASE_LAST) begin
          state_nxt = ST_IDLE;
          done_nxt = 1'b1;
          unique case (cur_r.op)
            exec_pkg::OP_ADC_ACC: begin
              acc_nxt = add_res.sum;
              flags_nxt.overflow_flag = add_res.ov;
              flags_nxt.zero_flag = add_res.z;
              flags_nxt.auxiliary_carry_flag = add_res.ac;
              flags_nxt.carry_flag = add_res.c;
            end
            exec_pkg::OP_ADC_MEM: begin
              mem_we = 1'b1;
              flags_nxt.overflow_flag = add_res.ov;
              flags_nxt.zero_flag = add_res.z;
              flags_nxt.auxiliary_carry_flag = add_res.ac;
              flags_nxt.carry_flag = add_res.c;
            end
            exec_pkg::OP_AND_ACC: begin
              acc_nxt = acc_r & mem_rd;
              flags_nxt.zero_flag = ((acc_r & mem_rd) == exec_pkg::ZERO_BYTE);
            end
            exec_pkg::OP_CPL_ACC: begin
              acc_nxt = ~mem_rd;
              flags_nxt.zero_flag = (~mem_rd == exec_pkg::ZERO_BYTE);
            end
            exec_pkg::OP_SKIP_BIT_ZERO, exec_pkg::OP_SKIP_BIT_SET: begin
              skip_nxt = bit_of(mem_rd, cur_r.bit_idx)
                         ^ (cur_r.op == exec_pkg::OP_SKIP_BIT_ZERO);
              if (skip_nxt) begin
                state_nxt = ST_EXTRA;
                done_nxt = 1'b0;
              end
            end
            exec_pkg::OP_WR_PC_LOW: begin
              pcl_nxt = PC_LOW_DATA;
              state_nxt = ST_EXTRA;
              done_nxt = 1'b0;
            end
            exec_pkg::OP_WDT_CLEAR: begin
              wdt_nxt = '0;
              presc_nxt = '0;
              flags_nxt.watchdog_timeout_flag = 1'b0;
              flags_nxt.power_down_flag = 1'b0;
              pre1_nxt = 1'b0;
              pre2_nxt = 1'b0;
            end
            exec_pkg::OP_WDT_PRE_FIRST, exec_pkg::OP_WDT_PRE_SECOND: begin
              if (cur_r.op == exec_pkg::OP_WDT_PRE_FIRST) begin
                pre1_nxt = 1'b1;
              end else begin
                pre2_nxt = 1'b1;
              end
              if (pre1_nxt && pre2_nxt) begin
                wdt_nxt = '0;
                presc_nxt = '0;
                flags_nxt.watchdog_timeout_flag = 1'b0;
                flags_nxt.power_down_flag = 1'b0;
                pre1_nxt = 1'b0;
                pre2_nxt = 1'b0;
              end
            end
            exec_pkg::OP_HALT: begin
              wdt_nxt = '0;
              presc_nxt = '0;
              flags_nxt.power_down_flag = 1'b1;
              flags_nxt.watchdog_timeout_flag = 1'b0;
              state_nxt = ST_HALT;
            end
            default: begin
            end
          endcase
        end
      end
      ST_EXTRA: begin
        // Dummy cycle of four clocks, nothing changes
        if (phase_r == exec_pkg::PHASE_LAST) begin
          state_nxt = ST_IDLE;
          done_nxt = 1'b1;
        end
      end
      ST_HALT: begin
        phase_nxt = 2'h0;
        if (WAKE) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
    // Timeout set once, on the step onto the top; a saturated counter
    // raises no further events, so a later clear is not overridden
    if (&presc_r && !(&wdt_r) && &(wdt_r + {{(WDT_W-1){1'b0}}, 1'b1})
        && state_nxt != ST_HALT) begin
      flags_nxt.watchdog_timeout_flag = 1'b1;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      state_r <= ST_IDLE;
      phase_r <= 2'h0;
      cur_r <= '0;
      acc_r <= exec_pkg::ZERO_BYTE;
      pcl_r <= exec_pkg::ZERO_BYTE;
      flags_r <= '0;
      wdt_r <= '0;
      presc_r <= '0;
      pre1_r <= 1'b0;
      pre2_r <= 1'b0;
      done_r <= 1'b0;
      skip_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      cur_r <= cur_nxt;
      acc_r <= acc_nxt;
      pcl_r <= pcl_nxt;
      flags_r <= flags_nxt;
      wdt_r <= wdt_nxt;
      presc_r <= presc_nxt;
      pre1_r <= pre1_nxt;
      pre2_r <= pre2_nxt;
      done_r <= done_nxt;
      skip_r <= skip_nxt;
    end
  end
  // Memory clears on reset, so no operand starts out unknown
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (mem_we) begin
      mem_r[cur_r.addr] <= mem_wd;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  logic ready_r, sysclk_r, halted_r, wexp_r;
  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      ready_r <= 1'b0;
      sysclk_r <= 1'b1;
      halted_r <= 1'b0;
      wexp_r <= 1'b0;
    end else begin
      ready_r <= (state_nxt == ST_IDLE);
      sysclk_r <= (state_nxt != ST_HALT);
      halted_r <= (state_nxt == ST_HALT);
      wexp_r <= &wdt_nxt;
    end
  end
  assign INSTR_READY = ready_r;
  assign DONE = done_r;
  assign SKIP_NEXT = skip_r;
  assign ACC = acc_r;
  assign PROGRAM_COUNTER_LOW_BYTE = pcl_r;
  assign FLAGS = flags_r;
  assign WATCHDOG_COUNTER = wdt_r;
  assign WATCHDOG_EXPIRED = wexp_r;
  assign SYS_CLK_EN = sysclk_r;
  assign HALTED = halted_r;
endmodule : exec_core

// ---- design/exec_pkg.sv ----
package exec_pkg;

  // ****************************************
  // Datapath widths and timing
  // ****************************************
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int BIT_IDX_W = 3;
  // One instruction cycle is four system clocks
  localparam int CLKS_PER_CYCLE = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [3:0] NIB_MASK = 4'hF;

  // ****************************************
  // Operation codes presented by the decoder
  // ****************************************
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_ADC_ACC = 4'h1,
    OP_ADC_MEM = 4'h2,
    OP_AND_ACC = 4'h3,
    OP_CPL_ACC = 4'h4,
    OP_SKIP_BIT_ZERO = 4'h5,
    OP_SKIP_BIT_SET = 4'h6,
    OP_WR_PC_LOW = 4'h7,
    OP_WDT_CLEAR = 4'h8,
    OP_WDT_PRE_FIRST = 4'h9,
    OP_WDT_PRE_SECOND = 4'hA,
    OP_HALT = 4'hB
  } op_t;

  // Instruction request bundle
  typedef struct packed {
    op_t op;
    logic [ADDR_W-1:0] addr;
    logic [BIT_IDX_W-1:0] bit_idx;
  } instr_t;

  // Status flag bundle
  typedef struct packed {
    logic watchdog_timeout_flag;
    logic power_down_flag;
    logic overflow_flag;
    logic zero_flag;
    logic auxiliary_carry_flag;
    logic carry_flag;
  } flags_t;

  // Adder result bundle
  typedef struct packed {
    logic [DATA_W-1:0] sum;
    logic ov;
    logic z;
    logic ac;
    logic c;
  } add_res_t;

endpackage : exec_pkg

// ---- testbench/exec_core_asserts.sv ----
`timescale 1ns/1ps
// ****************************************
// Port-level checker for the execution core
// ****************************************
module exec_core_chk #(
  parameter int WDT_W = 16
) (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic INSTR_VALID,
  input wire exec_pkg::instr_t INSTR,
  input wire logic INSTR_READY,
  input wire logic DONE,
  input wire logic SKIP_NEXT,
  input wire logic [7:0] ACC,
  input wire logic [7:0] PROGRAM_COUNTER_LOW_BYTE,
  input wire exec_pkg::flags_t FLAGS,
  input wire logic [WDT_W-1:0] WATCHDOG_COUNTER,
  input wire logic SYS_CLK_EN,
  input wire logic HALTED,
  input wire logic WATCHDOG_EXPIRED
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  // Accepted request
  wire logic take;
  exec_pkg::op_t op;
  assign take = INSTR_VALID && INSTR_READY;
  assign op = INSTR.op;

  a_pcl_extra: assert property (take && op == exec_pkg::OP_WR_PC_LOW
    |-> ##1 (!DONE) [*8] ##1 DONE) else $error("pc low write length");
  a_plain_len: assert property (take && op inside {exec_pkg::OP_NOP,
    exec_pkg::OP_ADC_ACC, exec_pkg::OP_ADC_MEM, exec_pkg::OP_AND_ACC,
    exec_pkg::OP_CPL_ACC, exec_pkg::OP_WDT_CLEAR, exec_pkg::OP_WDT_PRE_FIRST,
    exec_pkg::OP_WDT_PRE_SECOND} |-> ##1 (!DONE) [*4] ##1 DONE)
    else $error("plain op length");
  a_skip_len: assert property (take && (op == exec_pkg::OP_SKIP_BIT_ZERO
    || op == exec_pkg::OP_SKIP_BIT_SET) |-> ##5 ((DONE && !SKIP_NEXT) or
    (!DONE ##4 (DONE && SKIP_NEXT)))) else $error("skip length");
  a_halt_entry: assert property (take && op == exec_pkg::OP_HALT |->
    ##5 (HALTED && !SYS_CLK_EN && FLAGS.power_down_flag &&
    !FLAGS.watchdog_timeout_flag && WATCHDOG_COUNTER == '0))
    else $error("halt entry");
  a_halt_keeps: assert property (HALTED && $past(HALTED) |->
    $stable(ACC) && $stable(PROGRAM_COUNTER_LOW_BYTE)) else $error("halt kept");
  a_and_flags: assert property (take && op == exec_pkg::OP_AND_ACC |->
    ##5 (DONE && FLAGS.zero_flag == (ACC == 8'h00) &&
    FLAGS.carry_flag == $past(FLAGS.carry_flag, 5) &&
    FLAGS.overflow_flag == $past(FLAGS.overflow_flag, 5)))
    else $error("and flags");
  a_cpl_zero: assert property (take && op == exec_pkg::OP_CPL_ACC |->
    ##5 (FLAGS.zero_flag == (ACC == 8'h00))) else $error("complement zero");
  a_clr_flags: assert property (take && op == exec_pkg::OP_WDT_CLEAR |->
    ##5 (!FLAGS.watchdog_timeout_flag && !FLAGS.power_down_flag))
    else $error("clear flags");
  a_pd_fall: assert property ($fell(FLAGS.power_down_flag) |->
    DONE && WATCHDOG_COUNTER == '0) else $error("power-down fall");
  a_exp_top: assert property (WATCHDOG_EXPIRED == (&WATCHDOG_COUNTER))
    else $error("expiry flag");
endmodule : exec_core_chk

bind exec_core exec_core_chk #(.WDT_W(WDT_W)) i_chk (.MCLK(MCLK), .RSTN(RSTN),
  .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .INSTR_READY(INSTR_READY),
  .DONE(DONE), .SKIP_NEXT(SKIP_NEXT), .ACC(ACC), .FLAGS(FLAGS),
  .PROGRAM_COUNTER_LOW_BYTE(PROGRAM_COUNTER_LOW_BYTE), .HALTED(HALTED),
  .WATCHDOG_COUNTER(WATCHDOG_COUNTER), .SYS_CLK_EN(SYS_CLK_EN),
  .WATCHDOG_EXPIRED(WATCHDOG_EXPIRED));

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  // ****************************************
  // Expected result notes
  // ****************************************
  typedef struct {
    int lat;
    logic [7:0] program_counter_low_byte;
    logic z;
    logic [1:0] tp; // Timeout and power-down
    bit ctp;
    bit halt;
    logic [7:0] acc;
    logic [2:0] ar; // Overflow, aux carry, carry
    logic skp;
  } note_t;
  logic MCLK, RSTN, INSTR_VALID, WAKE, exp_z, halted_q;
  logic WATCHDOG_EXPIRED, exp_skp;
  logic [7:0] exp_acc, addr_q;
  logic [2:0] exp_ar;
  logic INSTR_READY, DONE, SKIP_NEXT, SYS_CLK_EN, HALTED;
  exec_pkg::instr_t INSTR;
  exec_pkg::flags_t FLAGS;
  logic [7:0] PC_LOW_DATA, ACC, PROGRAM_COUNTER_LOW_BYTE, exp_pcl;
  logic [2:0] WATCHDOG_COUNTER;
  note_t q[$];
  int err_count, checks_done, cnt, k;

  // Small watchdog so expiry comes within tens of clocks
  exec_core #(.WDT_W(3), .PRESC_W(2)) i_dut (.MCLK(MCLK), .RSTN(RSTN),
    .INSTR_VALID(INSTR_VALID), .INSTR(INSTR), .PC_LOW_DATA(PC_LOW_DATA),
    .WAKE(WAKE), .INSTR_READY(INSTR_READY), .DONE(DONE),
    .SKIP_NEXT(SKIP_NEXT), .ACC(ACC), .FLAGS(FLAGS), .HALTED(HALTED),
    .PROGRAM_COUNTER_LOW_BYTE(PROGRAM_COUNTER_LOW_BYTE),
    .WATCHDOG_COUNTER(WATCHDOG_COUNTER),
    .WATCHDOG_EXPIRED(WATCHDOG_EXPIRED),
    .SYS_CLK_EN(SYS_CLK_EN));

  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("checks_done=%0d err_count=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // ****************************************
  // Monitor: pops a note per completion
  // ****************************************
  always @(posedge MCLK) begin : mon
    note_t n;
    cnt = cnt + 1;
    if ((DONE === 1'b1 || (HALTED === 1'b1 && halted_q !== 1'b1))
        && q.size() > 0) begin
      n = q.pop_front();
      chk(16'(cnt), 16'(n.lat));
      chk({8'h00, PROGRAM_COUNTER_LOW_BYTE}, {8'h00, n.program_counter_low_byte});
      chk({7'h00, FLAGS.zero_flag, ACC}, {7'h00, n.z, n.acc});
      chk({12'h0, FLAGS[3], FLAGS[1:0], SKIP_NEXT},
          {12'h0, n.ar, n.skp});
      if (n.ctp) begin
        chk({14'h0, FLAGS[5:4]}, {14'h0, n.tp});
      end
      if (n.halt) begin
        chk({SYS_CLK_EN, 12'h0, WATCHDOG_COUNTER}, 16'h0000);
      end
    end
    halted_q = HALTED;
    if (INSTR_READY === 1'b1 && INSTR_VALID === 1'b1) begin
      cnt = 0;
    end
  end

  // Issue one instruction and wait for its completion or halt
  task automatic run(input exec_pkg::op_t op, input int lat, input bit ctp,
                     input logic [1:0] tp);
    int i;
    i = 0;
    while (INSTR_READY !== 1'b1 && i < 40) begin
      @(posedge MCLK);
      i++;
    end
    if (op == exec_pkg::OP_WR_PC_LOW) begin
      exp_pcl = 8'($urandom);
      PC_LOW_DATA <= exp_pcl;
    end else begin
      PC_LOW_DATA <= 8'($urandom);
    end
    q.push_back('{lat, exp_pcl, exp_z, tp, ctp, op == exec_pkg::OP_HALT,
                  exp_acc, exp_ar, exp_skp});
    INSTR_VALID <= 1'b1;
    INSTR <= '{op: op, addr: addr_q, bit_idx: 3'($urandom)};
    @(posedge MCLK);
    INSTR_VALID <= 1'b0;
    do begin
      @(posedge MCLK);
      i++;
    end while (INSTR_READY !== 1'b1 && HALTED !== 1'b1 && i < 80);
    if (i >= 80) begin
      err_count++;
      final_report();
    end
  endtask : run

  // Wait for the watchdog to raise its timeout flag
  task automatic expire();
    int i;
    for (i = 0; i < 200 && FLAGS.watchdog_timeout_flag !== 1'b1; i++) begin
      @(posedge MCLK);
    end
    if (i >= 200) begin
      err_count++;
      final_report();
    end
    chk({15'h0000, WATCHDOG_EXPIRED}, 16'h0001);
  endtask : expire

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h75C41E7B));
    {RSTN, INSTR_VALID, WAKE, exp_z, halted_q} = 5'h00;
    INSTR = '0;
    PC_LOW_DATA = 8'h00;
    exp_pcl = 8'h00;
    exp_acc = 8'h00;
    exp_ar = 3'h0;
    exp_skp = 1'b0;
    addr_q = 8'($urandom);
    err_count = 0;
    checks_done = 0;
    cnt = 0;
    repeat (4) @(posedge MCLK);
    RSTN <= 1'b1;
    chk({FLAGS, ACC, SYS_CLK_EN, INSTR_READY}, 16'h0002);
    @(posedge MCLK);
    run(exec_pkg::OP_NOP, 5, 1'b0, 2'h0);
    run(exec_pkg::OP_WR_PC_LOW, 9, 1'b0, 2'h0);
    run(exec_pkg::OP_WR_PC_LOW, 9, 1'b0, 2'h0);
    exp_z = 1'b1;
    run(exec_pkg::OP_AND_ACC, 5, 1'b0, 2'h0);
    // Memory starts cleared: bit zero skips, bit set does not
    exp_skp = 1'b1;
    run(exec_pkg::OP_SKIP_BIT_ZERO, 9, 1'b0, 2'h0);
    exp_skp = 1'b0;
    run(exec_pkg::OP_SKIP_BIT_SET, 5, 1'b0, 2'h0);
    {exp_acc, exp_z} = {8'hFF, 1'b0};
    run(exec_pkg::OP_CPL_ACC, 5, 1'b0, 2'h0);
    // FF plus zero plus no carry lands in memory, register unchanged
    run(exec_pkg::OP_ADC_MEM, 5, 1'b0, 2'h0);
    exp_skp = 1'b1;
    run(exec_pkg::OP_SKIP_BIT_SET, 9, 1'b0, 2'h0);
    // FF plus FF gives FE with carry and half carry, no overflow
    {exp_acc, exp_ar, exp_skp} = {8'hFE, 3'h3, 1'b0};
    run(exec_pkg::OP_ADC_ACC, 5, 1'b0, 2'h0);
    // FE plus FF plus carry stores FE back, flags as before
    run(exec_pkg::OP_ADC_MEM, 5, 1'b0, 2'h0);
    // Complement reads FE twice: the first must not rewrite memory
    exp_acc = 8'h01;
    run(exec_pkg::OP_CPL_ACC, 5, 1'b0, 2'h0);
    run(exec_pkg::OP_CPL_ACC, 5, 1'b0, 2'h0);
    run(exec_pkg::OP_HALT, 5, 1'b1, 2'h1);
    WAKE <= 1'b1;
    repeat (2) @(posedge MCLK);
    WAKE <= 1'b0;
    run(exec_pkg::OP_NOP, 5, 1'b0, 2'h0);
    // Both orders of the preclear pair; repeats must not clear
    for (k = 0; k < 2; k++) begin
      expire();
      run(k ? exec_pkg::OP_WDT_PRE_SECOND : exec_pkg::OP_WDT_PRE_FIRST, 5,
          1'b1, {1'b1, k == 0});
      run(k ? exec_pkg::OP_WDT_PRE_SECOND : exec_pkg::OP_WDT_PRE_FIRST, 5,
          1'b1, {1'b1, k == 0});
      run(k ? exec_pkg::OP_WDT_PRE_FIRST : exec_pkg::OP_WDT_PRE_SECOND, 5,
          1'b1, 2'h0);
    end
    expire();
    run(exec_pkg::OP_WDT_CLEAR, 5, 1'b1, 2'h0);
    final_report();
  end
endmodule : tb_top
